/* File: rtl/fspm_pkg.sv */
// Purpose: Shared constants and types for flash self-program mode control
// Assumes: 25 MHz ref_clk, Avalon-MM register slave with 32-bit data
// Notes:   Register offsets are word addresses on the slave
package fspm_pkg;

  localparam int          FSPM_CLK_MHZ      = 25;
  localparam int          FSPM_HALT_REL_US  = 10;
  localparam int          FSPM_HALT_XTRA    = 2;
  // Longest time rounds up: 10 us at 25 MHz plus two cycles
  localparam int          FSPM_HALT_CYC     =
    FSPM_HALT_REL_US * FSPM_CLK_MHZ + FSPM_HALT_XTRA;
  localparam int          FSPM_CNT_W        = 9;

  localparam logic [3:0]  FSPM_ADR_MODE     = 4'h0;
  localparam logic [3:0]  FSPM_ADR_PROT     = 4'h1;
  localparam logic [3:0]  FSPM_ADR_STAT     = 4'h2;
  localparam logic [3:0]  FSPM_ADR_FCMD     = 4'h3;
  localparam logic [3:0]  FSPM_ADR_CTRL     = 4'h4;

  localparam logic [7:0]  FSPM_PROT_KEY     = 8'hA5;
  localparam int          FSPM_SEL_BIT      = 0;
  localparam int          FSPM_MIR_LO       = 2;
  localparam int          FSPM_MIR_HI       = 6;
  localparam int          FSPM_STAT_ERR     = 0;
  localparam int          FSPM_STAT_SPM     = 1;
  localparam int          FSPM_STAT_BUSY    = 2;
  localparam int          FSPM_STAT_STBY    = 3;
  localparam int          FSPM_CTRL_HALT    = 0;
  localparam logic [2:0]  FSPM_FCMD_MASK    = 3'h7;
  localparam logic [31:0] FSPM_ZERO32       = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_KEYED = 3'b001,
    SEQ_VAL   = 3'b010,
    SEQ_INV   = 3'b011
  } fspm_seq_t;

  typedef enum logic [1:0] {
    RUN_NORMAL = 2'b00,
    RUN_STBY   = 2'b01,
    RUN_FLASH  = 2'b10
  } fspm_run_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } fspm_bus_req_t;

endpackage

/* File: rtl/fspm_mode_ctrl.sv */
// Purpose: Flash self-program mode control with protected mode writes
// Assumes: Single clock ref_clk; protect byte is a static configured input
// Notes:   Avalon-MM slave, waitrequest high for one cycle per access
`timescale 1ns/10ps
module fspm_mode_ctrl
  import fspm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  protect_byte,
  input  wire logic        cpu_halt,
  output logic             self_prog_select,
  output logic             cpu_standby,
  output logic             flash_start,
  output logic      [2:0]  flash_command_reg
);

  fspm_bus_req_t req;
  assign req = '{read: avs_read, write: avs_write,
                 address: avs_address, writedata: avs_writedata};

  // Waitrequest is registered: high when idle and in the first cycle of
  // a request, low in the cycle at whose end the request is taken
  logic        next_waitrequest;
  logic [31:0] next_readdata;
  logic        wr;
  logic        rd;

  fspm_seq_t   seq;
  fspm_seq_t   next_seq;
  logic        seqVal;
  logic        next_seqVal;
  logic [4:0]  protectMirror;
  logic [4:0]  next_protectMirror;
  logic        mirrorLoaded;
  logic        next_mirrorLoaded;
  logic        protErr;
  logic        next_protErr;
  logic        next_select;
  logic [2:0]  next_fcmd;

  fspm_run_t   run;
  fspm_run_t   next_run;
  logic [FSPM_CNT_W-1:0] haltCnt;
  logic [FSPM_CNT_W-1:0] next_haltCnt;
  logic        next_standby;
  logic        next_start;
  logic        haltSeen;
  logic        next_haltSeen;
  // Last count of a flash run: the 10 us window, with the two spare
  // cycles left for halt capture and the return to normal
  localparam logic [FSPM_CNT_W-1:0] HALT_LAST =
    FSPM_CNT_W'(FSPM_HALT_CYC - FSPM_HALT_XTRA);

  function automatic logic [7:0] mode_image(input logic       sel,
                                            input logic [4:0] mir);
    logic [7:0] img;
    img = 8'h00;
    img[FSPM_SEL_BIT] = sel;
    img[FSPM_MIR_HI:FSPM_MIR_LO] = mir;
    return img;
  endfunction

  function automatic logic [7:0] status_image(input logic err,
                                              input logic sel,
                                              input logic busy,
                                              input logic stby);
    logic [7:0] img;
    img = 8'h00;
    img[FSPM_STAT_ERR]  = err;
    img[FSPM_STAT_SPM]  = sel;
    img[FSPM_STAT_BUSY] = busy;
    img[FSPM_STAT_STBY] = stby;
    return img;
  endfunction

  // A key sequence stays open from the key until its last store
  function automatic logic seq_open(input fspm_seq_t s);
    return (s != SEQ_IDLE);
  endfunction

  // Stores land on the edge that takes them; read data is fetched one
  // cycle early so that it stands when the request is taken
  assign wr = req.write && !avs_waitrequest;
  assign rd = req.read && avs_waitrequest;

  // Bus handshake and read mux
  always_comb begin
    next_waitrequest = !((req.read || req.write) && avs_waitrequest);
    next_readdata    = avs_readdata;
    if (rd) begin
      next_readdata = FSPM_ZERO32;
      case (req.address)
        FSPM_ADR_MODE: begin
          // The mirror's next value, so a read in the loading cycle sees it
          next_readdata[7:0] = mode_image(self_prog_select,
                                          next_protectMirror);
        end
        FSPM_ADR_STAT: begin
          next_readdata[7:0] = status_image(protErr, self_prog_select,
                                            (run == RUN_FLASH),
                                            cpu_standby);
        end
        FSPM_ADR_FCMD: begin
          next_readdata[2:0] = flash_command_reg;
        end
        default: begin
          next_readdata = FSPM_ZERO32;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= FSPM_ZERO32;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // Protected write sequence and mode register
  always_comb begin
    next_seq           = seq;
    next_seqVal        = seqVal;
    next_protErr       = protErr;
    next_select        = self_prog_select;
    next_fcmd          = flash_command_reg;
    next_protectMirror = protectMirror;
    next_mirrorLoaded  = 1'b1;
    // The mirror loads once, on the first edge after reset
    if (!mirrorLoaded) begin
      next_protectMirror = protect_byte;
    end
    if (wr) begin
      case (req.address)
        FSPM_ADR_PROT: begin
          if (req.writedata[7:0] == FSPM_PROT_KEY) begin
            next_seq = SEQ_KEYED;
          end else begin
            next_seq = SEQ_IDLE;
          end
          if (seq_open(seq)) begin
            next_protErr = 1'b1;
          end
        end
        FSPM_ADR_MODE: begin
          case (seq)
            SEQ_KEYED: begin
              next_seqVal = req.writedata[FSPM_SEL_BIT];
              next_seq    = SEQ_VAL;
            end
            SEQ_VAL: begin
              if (req.writedata[FSPM_SEL_BIT] == !seqVal) begin
                next_seq = SEQ_INV;
              end else begin
                next_seq     = SEQ_IDLE;
                next_protErr = 1'b1;
              end
            end
            SEQ_INV: begin
              next_seq = SEQ_IDLE;
              if (req.writedata[FSPM_SEL_BIT] == seqVal) begin
                // Only the select bit is writable
                next_select = seqVal;
              end else begin
                next_protErr = 1'b1;
              end
            end
            default: begin
              next_seq     = SEQ_IDLE;
              next_protErr = 1'b1;
            end
          endcase
        end
        FSPM_ADR_STAT: begin
          if (!req.writedata[FSPM_STAT_ERR]) begin
            next_protErr = 1'b0;
          end
          // A store here breaks an open sequence; that error beats the clear
          if (seq_open(seq)) begin
            next_seq     = SEQ_IDLE;
            next_protErr = 1'b1;
          end
        end
        FSPM_ADR_FCMD: begin
          // Only the three command bits are kept
          next_fcmd = req.writedata[2:0] & FSPM_FCMD_MASK;
          if (seq_open(seq)) begin
            next_seq     = SEQ_IDLE;
            next_protErr = 1'b1;
          end
        end
        default: begin
          if (seq_open(seq)) begin
            next_seq     = SEQ_IDLE;
            next_protErr = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq               <= SEQ_IDLE;
      seqVal            <= 1'b0;
      protErr           <= 1'b0;
      self_prog_select  <= 1'b0;
      flash_command_reg <= 3'h0;
      protectMirror     <= 5'h00;
      mirrorLoaded      <= 1'b0;
    end else begin
      seq               <= next_seq;
      seqVal            <= next_seqVal;
      protErr           <= next_protErr;
      self_prog_select  <= next_select;
      flash_command_reg <= next_fcmd;
      protectMirror     <= next_protectMirror;
      mirrorLoaded      <= next_mirrorLoaded;
    end
  end

  // Halt handling: standby or flash operation with bounded release
  always_comb begin
    next_run      = run;
    next_haltCnt  = haltCnt;
    next_standby  = 1'b0;
    next_start    = 1'b0;
    next_haltSeen = cpu_halt;
    case (run)
      RUN_NORMAL: begin
        // Only the rising edge of halt starts standby or a flash run
        if (cpu_halt && !haltSeen) begin
          if (self_prog_select) begin
            next_run     = RUN_FLASH;
            next_start   = 1'b1;
            next_haltCnt = '0;
          end else begin
            next_run     = RUN_STBY;
            next_standby = 1'b1;
          end
        end
      end
      RUN_STBY: begin
        // Standby follows the halt level until the CPU drops it
        next_standby = cpu_halt;
        if (!cpu_halt) begin
          next_run = RUN_NORMAL;
        end
      end
      RUN_FLASH: begin
        if (haltCnt >= HALT_LAST) begin
          next_run = RUN_NORMAL;
        end else begin
          next_haltCnt = haltCnt + FSPM_CNT_W'(1);
        end
      end
      default: begin
        next_run = RUN_NORMAL;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run         <= RUN_NORMAL;
      haltCnt     <= '0;
      cpu_standby <= 1'b0;
      flash_start <= 1'b0;
      haltSeen    <= 1'b0;
    end else begin
      run         <= next_run;
      haltCnt     <= next_haltCnt;
      cpu_standby <= next_standby;
      flash_start <= next_start;
      haltSeen    <= next_haltSeen;
    end
  end

  // Busy shown in status; halt release is the return of run to normal

endmodule

/* File: verification/fspm_cpu_model.sv */
// Purpose: CPU core model that issues the halt instruction
// Assumes: haltGo is a one-cycle request from the bench
// Notes:   HOLD sets how long halt stays high
`timescale 1ns/10ps
module fspm_cpu_model #(parameter int HOLD = 20) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic haltGo,
  output logic      cpu_halt
);
  int cnt;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt      <= 0;
      cpu_halt <= 1'b0;
    end else if (haltGo) begin
      // One no-op cycle before the halt
      cnt <= HOLD + 1;
    end else if (cnt > 0) begin
      cnt      <= cnt - 1;
      cpu_halt <= (cnt <= HOLD);
    end else begin
      cpu_halt <= 1'b0;
    end
  end
endmodule

/* File: verification/fspm_mode_ctrl_asserts.sv */
// Purpose: Port checks for the mode control block
// Assumes: Bound to every instance of the block
// Notes:   Covers mark the main scenarios
`timescale 1ns/10ps
module fspm_mode_ctrl_asserts
  import fspm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  protect_byte,
  input wire logic        cpu_halt,
  input wire logic        self_prog_select,
  input wire logic        cpu_standby,
  input wire logic        flash_start,
  input wire logic [2:0]  flash_command_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sel_after_rst_a: assert property ($past(sys_rst) |->
    !self_prog_select)
    else $error("select set after reset");
  mode_read_a: assert property (
    avs_read && !avs_waitrequest &&
    avs_address == FSPM_ADR_MODE |-> avs_readdata[7:0] ==
    {1'b0, protect_byte, 1'b0, self_prog_select})
    else $error("mode read value wrong");
  halt_start_a: assert property ($rose(cpu_halt) &&
    self_prog_select |=> flash_start)
    else $error("halt did not start flash");
  start_once_a: assert property (flash_start |=> !flash_start)
    else $error("start pulse too long");
  no_start_a: assert property (!self_prog_select |=> !flash_start)
    else $error("start in normal mode");
  stby_on_a: assert property (cpu_halt &&
    !self_prog_select |=> cpu_standby)
    else $error("no standby on halt");
  stby_off_a: assert property (!cpu_halt |=> !cpu_standby)
    else $error("standby without halt");
  spm_no_stby_a: assert property (self_prog_select |-> !cpu_standby)
    else $error("standby in self program");
  sel_by_write_a: assert property ($changed(self_prog_select) |->
    $past(avs_write && !avs_waitrequest && avs_address == FSPM_ADR_MODE))
    else $error("select changed without write");
  cover property (flash_start);
  cover property (cpu_standby);
  cover property ($rose(self_prog_select));
endmodule
bind fspm_mode_ctrl fspm_mode_ctrl_asserts i_fspm_mode_ctrl_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .protect_byte(protect_byte),
  .cpu_halt(cpu_halt), .self_prog_select(self_prog_select),
  .cpu_standby(cpu_standby), .flash_start(flash_start),
  .flash_command_reg(flash_command_reg));

/* File: verification/tb_fspm_mode_ctrl.sv */
// Purpose: Register-level bench for the mode control block
// Assumes: Avalon-MM master tasks, CPU model drives halt
// Notes:   Status bits are error, select, busy, standby
`timescale 1ns/10ps
module tb_fspm_mode_ctrl
  import fspm_pkg::*;
;
  localparam logic [4:0]  PB = 5'h15;
  localparam logic [31:0] MD = {24'h00_0000, 1'b0, PB, 2'b00};
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        haltGo = 1'b0;
  logic        cpu_halt;
  logic        selOut;
  logic        stbyOut;
  logic        startOut;
  logic [2:0]  fcmdOut;
  int          errorCnt = 0;
  int          samplesChecked = 0;
  fspm_mode_ctrl i_fspm_mode_ctrl (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .protect_byte(PB),
    .cpu_halt(cpu_halt), .self_prog_select(selOut),
    .cpu_standby(stbyOut), .flash_start(startOut),
    .flash_command_reg(fcmdOut));
  fspm_cpu_model i_fspm_cpu_model (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .haltGo(haltGo),
    .cpu_halt(cpu_halt));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic endSim();
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samplesChecked++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic r,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= r;
    avs_write     <= !r;
    // Sampled at the edge, so the values are those the slave presented
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b0, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b1, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // Clear the command field, then the keyed four-store sequence
  task automatic key(input logic [31:0] v, input logic [31:0] i);
    wr(FSPM_ADR_FCMD, 32'h0000_0000);
    wr(FSPM_ADR_PROT, 32'h0000_00A5);
    wr(FSPM_ADR_MODE, v);
    wr(FSPM_ADR_MODE, i);
    wr(FSPM_ADR_MODE, v);
  endtask
  task automatic halt();
    @(posedge ref_clk);
    haltGo <= 1'b1;
    @(posedge ref_clk);
    haltGo <= 1'b0;
    @(posedge cpu_halt);
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    errorCnt++;
    endSim();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(FSPM_ADR_MODE, MD);
    wr(FSPM_ADR_MODE, 32'h0000_00FF);
    rdc(FSPM_ADR_MODE, MD);
    rdc(FSPM_ADR_STAT, 32'h0000_0001);
    wr(FSPM_ADR_STAT, 32'h0000_0000);
    halt();
    rdc(FSPM_ADR_STAT, 32'h0000_0008);
    chk({31'h0, stbyOut}, 32'h0000_0001);
    repeat (25) @(posedge ref_clk);
    rdc(FSPM_ADR_STAT, 32'h0000_0000);
    chk({31'h0, stbyOut}, 32'h0000_0000);
    key(32'h0000_0001, 32'h0000_00FE);
    rdc(FSPM_ADR_MODE, MD | 32'h0000_0001);
    chk({31'h0, selOut}, 32'h0000_0001);
    wr(FSPM_ADR_FCMD, 32'h0000_0005);
    rdc(FSPM_ADR_FCMD, 32'h0000_0005);
    chk({29'h0, fcmdOut}, 32'h0000_0005);
    halt();
    repeat (2) @(posedge ref_clk);
    chk({31'h0, startOut}, 32'h0000_0001);
    repeat (198) @(posedge ref_clk);
    rdc(FSPM_ADR_STAT, 32'h0000_0006);
    repeat (50) @(posedge ref_clk);
    rdc(FSPM_ADR_STAT, 32'h0000_0002);
    // Settle time for an external system clock
    repeat (200) @(posedge ref_clk);
    key(32'h0000_0000, 32'h0000_0000);
    rdc(FSPM_ADR_STAT, 32'h0000_0003);
    chk({29'h0, fcmdOut}, 32'h0000_0000);
    wr(FSPM_ADR_STAT, 32'h0000_0000);
    key(32'h0000_0000, 32'h0000_00FF);
    rdc(FSPM_ADR_MODE, MD);
    wr(4'hF, 32'h0000_00FF);
    rdc(4'hF, 32'h0000_0000);
    key(32'h0000_0001, 32'h0000_00FE);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdc(FSPM_ADR_MODE, MD);
    endSim();
  end
endmodule
